// [scz_pkg.sv]
// Package of constants and types for the calibration and zeroing controller
package scz_pkg;

    // ==========================================================
    // Command codes
    typedef enum logic [2:0] {
        SCZ_CMD_CAL_AUTO = 3'b000,
        SCZ_CMD_ZERO_AUTO = 3'b001,
        SCZ_CMD_ZERO_TYPE = 3'b010,
        SCZ_CMD_QUICK = 3'b011,
        SCZ_CMD_ALL = 3'b100
    } scz_cmd_e;

    // Argument codes
    typedef enum logic [2:0] {
        SCZ_ARG_OFF = 3'b000,
        SCZ_ARG_ON = 3'b001,
        SCZ_ARG_SINGLE_SHOT = 3'b010,
        SCZ_ARG_INT = 3'b011,
        SCZ_ARG_EXT = 3'b100
    } scz_arg_e;

    // Routine sequencer states
    typedef enum logic [2:0] {
        SCZ_ST_IDLE = 3'b000,
        SCZ_ST_ZERO = 3'b001,
        SCZ_ST_ZERO_WAIT = 3'b010,
        SCZ_ST_CAL = 3'b011,
        SCZ_ST_CAL_WAIT = 3'b100
    } scz_state_e;

    // Command carrier
    typedef struct packed {
        scz_cmd_e cmd;
        scz_arg_e arg;
    } scz_cmd_s;

    // Error report carrier
    typedef struct packed {
        logic [8:0] code;
        logic zero_qual;
        logic cal_qual;
        logic list_qual;
    } scz_err_s;

    // ==========================================================
    // Error magnitudes (reported as the positive value of the negative code)
    localparam logic [8:0] SCZ_ERR_CONFLICT = 9'h0DD;
    localparam logic [8:0] SCZ_ERR_ILLEGAL = 9'h0E0;
    localparam logic [8:0] SCZ_ERR_QUESTION = 9'h0E7;

    // Timing
    localparam longint SCZ_CLK_HZ = 64'd100_000_000;
    localparam longint SCZ_CAL_PERIOD_S = 64'd600;
    localparam longint SCZ_ZERO_PERIOD_S = 64'd86_400;
    localparam longint SCZ_CAL_CYCLES = SCZ_CAL_PERIOD_S * SCZ_CLK_HZ;
    localparam longint SCZ_ZERO_CYCLES = SCZ_ZERO_PERIOD_S * SCZ_CLK_HZ;

    // Reset values
    localparam logic SCZ_RST_CAL_AUTO = 1'b0;
    localparam logic SCZ_RST_ZERO_AUTO = 1'b0;
    localparam logic SCZ_RST_ZERO_EXT = 1'b0;

endpackage

// [scz_ctrl.sv]
// Calibration and zeroing command controller
`timescale 1ns/10ps
module scz_ctrl
    import scz_pkg::*;
#(
    parameter longint CAL_CYCLES = SCZ_CAL_CYCLES,
    parameter longint ZERO_CYCLES = SCZ_ZERO_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Command input
    input wire logic cmd_valid,
    input wire scz_cmd_s cmd_in,
    // Device state
    input wire logic list_running,
    input wire logic normal_path_mode,
    input wire logic averaging_detector,
    // Measurement engine handshake
    output logic zero_start,
    output logic zero_quick_path,
    output logic zero_external,
    input wire logic zero_done,
    input wire logic zero_ok,
    output logic cal_start,
    input wire logic cal_done,
    input wire logic cal_ok,
    output logic fly_zero_enable,
    // Status
    output logic cal_auto_state,
    output logic zero_auto_state,
    output logic zero_source_ext,
    output logic quick_query,
    output logic busy,
    output logic all_done,
    output logic all_fail,
    // Errors
    output logic err_valid,
    output scz_err_s err_out
);

    // ==========================================================
    // Parameter checks
    if (CAL_CYCLES < 2 || CAL_CYCLES >= 64'h0001_0000_0000_0000) begin : g_bad_cal
        $error("scz_ctrl: calibration period out of range");
    end
    if (ZERO_CYCLES < 2 || ZERO_CYCLES >= 64'h0001_0000_0000_0000) begin : g_bad_zero
        $error("scz_ctrl: zeroing period out of range");
    end

    localparam logic [47:0] CAL_LAST = 48'(CAL_CYCLES - 1);
    localparam logic [47:0] ZERO_LAST = 48'(ZERO_CYCLES - 1);

    // ==========================================================
    // Decode helpers
    function automatic logic cmd_hit(input logic valid, input scz_cmd_s cmd_word, input scz_cmd_e code);
        return valid && cmd_word.cmd == code;
    endfunction

    function automatic logic arg_hit(input scz_cmd_s cmd_word, input scz_arg_e code);
        return cmd_word.arg == code;
    endfunction

    // ==========================================================
    // Command decode
    wire logic is_cal = cmd_hit(cmd_valid, cmd_in, SCZ_CMD_CAL_AUTO);
    wire logic is_zero = cmd_hit(cmd_valid, cmd_in, SCZ_CMD_ZERO_AUTO);
    wire logic is_type = cmd_hit(cmd_valid, cmd_in, SCZ_CMD_ZERO_TYPE);
    wire logic is_quick = cmd_hit(cmd_valid, cmd_in, SCZ_CMD_QUICK);
    wire logic is_all = cmd_hit(cmd_valid, cmd_in, SCZ_CMD_ALL);
    wire logic a_off = arg_hit(cmd_in, SCZ_ARG_OFF);
    wire logic a_on = arg_hit(cmd_in, SCZ_ARG_ON);
    wire logic a_single_shot = arg_hit(cmd_in, SCZ_ARG_SINGLE_SHOT);
    wire logic a_int = arg_hit(cmd_in, SCZ_ARG_INT);
    wire logic a_ext = arg_hit(cmd_in, SCZ_ARG_EXT);

    wire logic cal_on_conflict = is_cal && a_on && list_running;
    wire logic zero_on_conflict = is_zero && a_on && zero_source_ext;
    wire logic type_illegal = is_type && !a_int && !a_ext;
    wire logic quick_illegal = is_quick && !a_off && !a_single_shot;
    wire logic quick_conflict = is_quick && a_single_shot && averaging_detector;

    // ==========================================================
    // Settings
    logic cal_auto_next;
    logic zero_auto_next;
    logic zero_ext_next;
    assign cal_auto_next = (is_cal && a_on && !list_running) ? 1'b1 :
        (is_cal && a_off) ? 1'b0 : cal_auto_state;
    assign zero_ext_next = (is_type && a_ext) ? 1'b1 : (is_type && a_int) ? 1'b0 : zero_source_ext;
    assign zero_auto_next = (is_type && a_ext) ? 1'b0 :
        (is_zero && a_on && !zero_source_ext) ? 1'b1 :
        (is_zero && a_off) ? 1'b0 : zero_auto_state;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cal_auto_state <= SCZ_RST_CAL_AUTO;
            zero_auto_state <= SCZ_RST_ZERO_AUTO;
            zero_source_ext <= SCZ_RST_ZERO_EXT;
            quick_query <= 1'b0;
            fly_zero_enable <= 1'b0;
        end else begin
            cal_auto_state <= cal_auto_next;
            zero_auto_state <= zero_auto_next;
            zero_source_ext <= zero_ext_next;
            quick_query <= 1'b0;
            fly_zero_enable <= zero_auto_next && normal_path_mode;
        end
    end

    // ==========================================================
    // Periodic timers
    logic [47:0] cal_cnt_reg;
    logic [47:0] zero_cnt_reg;
    wire logic cal_tick = cal_auto_state && normal_path_mode && cal_cnt_reg == CAL_LAST;
    wire logic zero_fin;
    wire logic zero_tick = zero_auto_state && zero_cnt_reg == ZERO_LAST;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cal_cnt_reg <= 48'h0000_0000_0000;
            zero_cnt_reg <= 48'h0000_0000_0000;
        end else begin
            if (!cal_auto_state || !normal_path_mode || cal_tick) begin
                cal_cnt_reg <= 48'h0000_0000_0000;
            end else begin
                cal_cnt_reg <= cal_cnt_reg + 48'h0000_0000_0001;
            end
            if (!zero_auto_state || zero_fin || zero_tick) begin
                zero_cnt_reg <= 48'h0000_0000_0000;
            end else begin
                zero_cnt_reg <= zero_cnt_reg + 48'h0000_0000_0001;
            end
        end
    end

    // ==========================================================
    // Pending triggers (set wins over consume)
    logic pend_cal_reg;
    logic pend_zero_reg;
    logic pend_quick_reg;
    logic pend_all_reg;
    scz_state_e state_reg;
    scz_state_e state_next;
    logic seq_all_reg;
    logic seq_quick_reg;
    logic seq_fail_reg;

    wire logic idle = state_reg == SCZ_ST_IDLE;
    wire logic set_cal = (is_cal && a_single_shot) || cal_tick;
    wire logic set_zero = (is_zero && a_single_shot) || zero_tick;
    wire logic set_quick = is_quick && a_single_shot && !averaging_detector;
    wire logic take_all = idle && pend_all_reg;
    wire logic take_zero = idle && !pend_all_reg && (pend_zero_reg || pend_quick_reg);
    wire logic take_cal = idle && !pend_all_reg && !pend_zero_reg && !pend_quick_reg && pend_cal_reg;
    assign zero_fin = state_reg == SCZ_ST_ZERO_WAIT && zero_done && zero_ok;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pend_cal_reg <= 1'b0;
            pend_zero_reg <= 1'b0;
            pend_quick_reg <= 1'b0;
            pend_all_reg <= 1'b0;
        end else begin
            pend_all_reg <= is_all || (pend_all_reg && !take_all);
            pend_zero_reg <= set_zero || (pend_zero_reg && !take_zero);
            pend_quick_reg <= set_quick || (pend_quick_reg && !(take_zero && !pend_zero_reg));
            pend_cal_reg <= set_cal || (pend_cal_reg && !take_cal);
        end
    end

    // ==========================================================
    // Routine sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCZ_ST_IDLE: begin
                if (take_all || take_zero) begin
                    state_next = SCZ_ST_ZERO;
                end else if (take_cal) begin
                    state_next = SCZ_ST_CAL;
                end
            end
            SCZ_ST_ZERO: begin
                state_next = SCZ_ST_ZERO_WAIT;
            end
            SCZ_ST_ZERO_WAIT: begin
                if (zero_done) begin
                    state_next = seq_all_reg ? SCZ_ST_CAL : SCZ_ST_IDLE;
                end
            end
            SCZ_ST_CAL: begin
                state_next = SCZ_ST_CAL_WAIT;
            end
            SCZ_ST_CAL_WAIT: begin
                if (cal_done) begin
                    state_next = SCZ_ST_IDLE;
                end
            end
            default: begin
                state_next = SCZ_ST_IDLE;
            end
        endcase
    end

    wire logic zero_bad = state_reg == SCZ_ST_ZERO_WAIT && zero_done && !zero_ok;
    wire logic cal_bad = state_reg == SCZ_ST_CAL_WAIT && cal_done && !cal_ok;
    wire logic all_end = seq_all_reg && state_reg == SCZ_ST_CAL_WAIT && cal_done;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= SCZ_ST_IDLE;
            seq_all_reg <= 1'b0;
            seq_quick_reg <= 1'b0;
            seq_fail_reg <= 1'b0;
            all_done <= 1'b0;
            all_fail <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (idle) begin
                seq_all_reg <= take_all;
                seq_quick_reg <= take_zero && !pend_zero_reg && !take_all;
                seq_fail_reg <= 1'b0;
            end else if (zero_bad) begin
                seq_fail_reg <= 1'b1;
            end
            if (take_all) begin
                all_done <= 1'b0;
            end else if (all_end) begin
                all_done <= 1'b1;
                all_fail <= seq_fail_reg || !cal_ok;
            end
        end
    end

    // ==========================================================
    // Engine strobes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            zero_start <= 1'b0;
            zero_quick_path <= 1'b0;
            zero_external <= 1'b0;
            cal_start <= 1'b0;
            busy <= 1'b0;
        end else begin
            zero_start <= state_next == SCZ_ST_ZERO;
            cal_start <= state_next == SCZ_ST_CAL;
            zero_quick_path <= state_reg == SCZ_ST_ZERO && seq_quick_reg;
            zero_external <= zero_source_ext;
            busy <= state_next != SCZ_ST_IDLE;
        end
    end

    // ==========================================================
    // Error reports, one per cycle in priority order
    wire logic err_any = zero_bad || cal_bad || cal_on_conflict || zero_on_conflict || quick_conflict ||
        type_illegal || quick_illegal;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            err_valid <= 1'b0;
            err_out <= '0;
        end else begin
            err_valid <= err_any;
            if (zero_bad) begin
                err_out <= '{SCZ_ERR_QUESTION, 1'b1, 1'b0, 1'b0};
            end else if (cal_bad) begin
                err_out <= '{SCZ_ERR_QUESTION, 1'b0, 1'b1, 1'b0};
            end else if (cal_on_conflict) begin
                err_out <= '{SCZ_ERR_CONFLICT, 1'b0, 1'b0, 1'b1};
            end else if (zero_on_conflict || quick_conflict) begin
                err_out <= '{SCZ_ERR_CONFLICT, 1'b0, 1'b0, 1'b0};
            end else if (type_illegal || quick_illegal) begin
                err_out <= '{SCZ_ERR_ILLEGAL, 1'b0, 1'b0, 1'b0};
            end
        end
    end

endmodule // scz_ctrl

// [scz_props.sv]
// Checker for the calibration and zeroing controller
`timescale 1ns/10ps
module scz_props
    import scz_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Commands and device state
    input wire logic cmd_valid,
    input wire scz_cmd_s cmd_in,
    input wire logic list_running,
    input wire logic normal_path_mode,
    // Engine handshake
    input wire logic zero_start,
    input wire logic zero_quick_path,
    input wire logic zero_done,
    input wire logic zero_ok,
    input wire logic cal_start,
    input wire logic cal_done,
    input wire logic cal_ok,
    input wire logic fly_zero_enable,
    // Status and errors
    input wire logic cal_auto_state,
    input wire logic zero_auto_state,
    input wire logic zero_source_ext,
    input wire logic quick_query,
    input wire logic busy,
    input wire logic all_done,
    input wire logic all_fail,
    input wire logic err_valid,
    input wire scz_err_s err_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Properties
    property p_cal_off;
        cmd_valid && cmd_in.cmd == SCZ_CMD_CAL_AUTO && cmd_in.arg == SCZ_ARG_OFF |=> !cal_auto_state;
    endproperty
    a_cal_off: assert property (p_cal_off) else $error("periodic cal still on after off");
    property p_ext_off;
        cmd_valid && cmd_in.cmd == SCZ_CMD_ZERO_TYPE && cmd_in.arg == SCZ_ARG_EXT
            |=> zero_source_ext && !zero_auto_state;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("external source left auto nulling on");
    property p_zon_conflict;
        cmd_valid && cmd_in.cmd == SCZ_CMD_ZERO_AUTO && cmd_in.arg == SCZ_ARG_ON && zero_source_ext
            |=> !zero_auto_state;
    endproperty
    a_zon_conflict: assert property (p_zon_conflict) else $error("auto nulling on with external source");
    property p_list_conflict;
        cmd_valid && cmd_in.cmd == SCZ_CMD_CAL_AUTO && cmd_in.arg == SCZ_ARG_ON && list_running && !cal_auto_state
            |=> !cal_auto_state;
    endproperty
    a_list_conflict: assert property (p_list_conflict) else $error("periodic cal on during list");
    property p_quick_zero;
        quick_query == 1'b0;
    endproperty
    a_quick_zero: assert property (p_quick_zero) else $error("quick query not zero");
    property p_fly_path;
        !normal_path_mode [*2] |-> !fly_zero_enable;
    endproperty
    a_fly_path: assert property (p_fly_path) else $error("fly zero outside standard path");
    property p_one_routine;
        zero_start || cal_start |-> busy && !(zero_start && cal_start);
    endproperty
    a_one_routine: assert property (p_one_routine) else $error("routine start overlap");
    property p_cal_fail;
        cal_done && !cal_ok |-> ##[1:3] err_valid && err_out.code == SCZ_ERR_QUESTION && err_out.cal_qual;
    endproperty
    a_cal_fail: assert property (p_cal_fail) else $error("cal failure not reported");
    property p_zero_fail;
        zero_done && !zero_ok |-> ##[1:3] err_valid && err_out.code == SCZ_ERR_QUESTION && err_out.zero_qual;
    endproperty
    a_zero_fail: assert property (p_zero_fail) else $error("zero failure not reported");
    property p_src_illegal;
        cmd_valid && cmd_in.cmd == SCZ_CMD_ZERO_TYPE && !busy && cmd_in.arg != SCZ_ARG_INT
            && cmd_in.arg != SCZ_ARG_EXT |=> err_valid && err_out.code == SCZ_ERR_ILLEGAL;
    endproperty
    a_src_illegal: assert property (p_src_illegal) else $error("bad source not refused");
    c_all_fail: cover property (all_done && all_fail);
    c_list_err: cover property (err_valid && err_out.list_qual);
    c_quick: cover property (zero_start ##1 zero_quick_path);
endmodule // scz_props

bind scz_ctrl scz_props u_props (.*);

// [scz_engine.sv]
// Measurement engine model answering zeroing and calibration starts
`timescale 1ns/10ps
module scz_engine (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Routine requests
    input wire logic zero_start,
    input wire logic cal_start,
    // Behaviour chosen by the bench
    input wire logic [3:0] lat,
    input wire logic fail_zero,
    input wire logic fail_cal,
    // Answers
    output logic zero_done,
    output logic zero_ok,
    output logic cal_done,
    output logic cal_ok
);
    logic [4:0] cnt_reg;
    logic is_cal_reg;
    logic res_reg;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 5'h0;
            is_cal_reg <= 1'b0;
            res_reg <= 1'b1;
        end else if (zero_start || cal_start) begin
            cnt_reg <= {1'b0, lat} + 5'h1;
            is_cal_reg <= cal_start;
            res_reg <= cal_start ? !fail_cal : !fail_zero;
        end else if (cnt_reg != 5'h0) begin
            cnt_reg <= cnt_reg - 5'h1;
        end
    end
    assign zero_done = (cnt_reg == 5'h1) && !is_cal_reg;
    assign cal_done = (cnt_reg == 5'h1) && is_cal_reg;
    // Result lines show the inverse outside the done pulse
    assign zero_ok = zero_done ? res_reg : !res_reg;
    assign cal_ok = cal_done ? res_reg : !res_reg;
endmodule // scz_engine

// [scz_ctrl_tb.sv]
// Self-checking bench for the calibration and zeroing controller
`timescale 1ns/10ps
module scz_ctrl_tb;
    import scz_pkg::*;
    localparam longint CAL_N = 50;
    localparam longint ZERO_N = 80;
    logic clk_sys, reset_n, cmd_valid, list_running, normal_path_mode, averaging_detector, err_valid, err_seen;
    logic zero_start, zero_quick_path, zero_external, zero_done, zero_ok, cal_start, cal_done, cal_ok, q_seen;
    logic fly_zero_enable, cal_auto_state, zero_auto_state, zero_source_ext, quick_query, busy, all_done, all_fail;
    logic fail_zero, fail_cal;
    logic [1:0] seq_log;
    logic [3:0] lat;
    logic [31:0] seed, r;
    scz_cmd_s cmd_in;
    scz_err_s err_out, err_cap;
    int num_errors, compares, n_zero, n_cal, cycles, c0;
    scz_ctrl #(.CAL_CYCLES(CAL_N), .ZERO_CYCLES(ZERO_N)) DUT (.*);
    scz_engine u_engine (.*);
    // ==========================================================
    // Clock, monitor and timeout
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (zero_start === 1'b1) n_zero++;
        if (zero_start === 1'b1) seq_log = {seq_log[0], 1'b0};
        if (cal_start === 1'b1) n_cal++;
        if (cal_start === 1'b1) seq_log = {seq_log[0], 1'b1};
        if (zero_quick_path === 1'b1) q_seen = 1'b1;
        if (err_valid === 1'b1) err_cap = err_out;
        if (err_valid === 1'b1) err_seen = 1'b1;
        if (cycles == 20000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            summarize();
        end
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic send(input scz_cmd_e c, input scz_arg_e a);
        cmd_in = {c, a};
        cmd_valid = 1'b1;
        err_seen = 1'b0;
        tick(1);
        cmd_valid = 1'b0;
        tick(2);
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        tick(3);
        while (busy !== 1'b0 && k < 300) begin
            tick(1);
            k++;
        end
        tick(3);
    endtask
    task automatic summarize();
        $display("Errors %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h6927_3107;
        {num_errors, compares, n_zero, n_cal, cycles} = '0;
        {reset_n, cmd_valid, list_running, normal_path_mode, averaging_detector, fail_zero, fail_cal} = '0;
        {err_seen, q_seen, seq_log, cmd_in} = '0;
        lat = 4'h3;
        repeat (12) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        tick(1);
        chk({cal_auto_state, zero_auto_state, zero_source_ext, quick_query, busy}, 0);
        send(SCZ_CMD_ZERO_AUTO, SCZ_ARG_ON);
        normal_path_mode = 1'b1;
        tick(2);
        chk({zero_auto_state, fly_zero_enable}, 2'b11);
        send(SCZ_CMD_ZERO_TYPE, SCZ_ARG_EXT);
        chk({zero_source_ext, zero_auto_state, zero_external}, 3'b101);
        send(SCZ_CMD_ZERO_AUTO, SCZ_ARG_ON);
        chk({err_seen, err_cap, zero_auto_state}, {1'b1, SCZ_ERR_CONFLICT, 4'h0});
        send(SCZ_CMD_ZERO_TYPE, SCZ_ARG_INT);
        chk(zero_source_ext, 0);
        for (int a = 0; a < 8; a++) begin
            if (a != 3 && a != 4) send(SCZ_CMD_ZERO_TYPE, scz_arg_e'(a));
            if (a != 3 && a != 4) chk({err_seen, err_cap}, {1'b1, SCZ_ERR_ILLEGAL, 3'b000});
        end
        send(SCZ_CMD_QUICK, SCZ_ARG_ON);
        chk({err_seen, err_cap}, {1'b1, SCZ_ERR_ILLEGAL, 3'b000});
        send(SCZ_CMD_QUICK, SCZ_ARG_OFF);
        chk({err_seen, busy}, 0);
        averaging_detector = 1'b1;
        send(SCZ_CMD_QUICK, SCZ_ARG_SINGLE_SHOT);
        chk({err_seen, err_cap, busy}, {1'b1, SCZ_ERR_CONFLICT, 4'h0});
        averaging_detector = 1'b0;
        fail_zero = 1'b1;
        send(SCZ_CMD_QUICK, SCZ_ARG_SINGLE_SHOT);
        wait_done();
        chk(q_seen, 1);
        chk({err_seen, err_cap}, {1'b1, SCZ_ERR_QUESTION, 3'b100});
        list_running = 1'b1;
        send(SCZ_CMD_CAL_AUTO, SCZ_ARG_ON);
        chk({err_seen, err_cap, cal_auto_state}, {1'b1, SCZ_ERR_CONFLICT, 4'b0010});
        list_running = 1'b0;
        fail_zero = 1'b0;
        send(SCZ_CMD_ZERO_AUTO, SCZ_ARG_SINGLE_SHOT);
        wait_done();
        fail_cal = 1'b1;
        c0 = n_cal;
        send(SCZ_CMD_CAL_AUTO, SCZ_ARG_SINGLE_SHOT);
        wait_done();
        chk({err_seen, err_cap}, {1'b1, SCZ_ERR_QUESTION, 3'b010});
        tick(100);
        chk(n_cal - c0, 1);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            lat = r[3:0];
            fail_zero = r[4];
            fail_cal = r[5];
            {seq_log, q_seen} = 3'b000;
            send(SCZ_CMD_ALL, scz_arg_e'(3'(r[15:8] % 5)));
            wait_done();
            chk({all_done, all_fail}, {1'b1, r[4] | r[5]});
            chk(seq_log, 2'b01);
            chk(q_seen, 0);
        end
        {fail_zero, fail_cal} = 2'b00;
        c0 = n_cal;
        cmd_in = {SCZ_CMD_ALL, SCZ_ARG_OFF};
        cmd_valid = 1'b1;
        tick(1);
        cmd_in = {SCZ_CMD_CAL_AUTO, SCZ_ARG_SINGLE_SHOT};
        tick(1);
        cmd_valid = 1'b0;
        wait_done();
        wait_done();
        chk(n_cal - c0, 2);
        lat = 4'h2;
        c0 = n_cal;
        send(SCZ_CMD_CAL_AUTO, SCZ_ARG_ON);
        chk(cal_auto_state, 1);
        tick(5 * CAL_N + 20);
        chk((n_cal - c0) inside {[4:6]}, 1);
        normal_path_mode = 1'b0;
        wait_done();
        c0 = n_cal;
        tick(150);
        chk(n_cal - c0, 0);
        normal_path_mode = 1'b1;
        send(SCZ_CMD_CAL_AUTO, SCZ_ARG_OFF);
        wait_done();
        c0 = n_cal;
        tick(200);
        chk({cal_auto_state, 31'(n_cal - c0)}, 0);
        c0 = n_zero;
        send(SCZ_CMD_ZERO_AUTO, SCZ_ARG_ON);
        tick(3 * ZERO_N);
        chk((n_zero - c0) inside {[2:4]}, 1);
        send(SCZ_CMD_ZERO_AUTO, SCZ_ARG_OFF);
        wait_done();
        c0 = n_zero;
        tick(200);
        chk({zero_auto_state, 31'(n_zero - c0)}, 0);
        summarize();
    end
endmodule // scz_ctrl_tb
